// ==== bibe_cfg.svh ====
// Constants for the bit, increment and branch execute block.
`ifndef BIBE_CFG_SVH
`define BIBE_CFG_SVH
`define BIBE_REG_STATUS 5'h03
`define BIBE_REG_CONFIG 5'h00
`define BIBE_REG_PC_LO 5'h01
`define BIBE_REG_PC_HI 5'h02
`define BIBE_REG_ACC 5'h04
`define BIBE_REG_FILE_BASE 5'h08
`define BIBE_STATUS_Z 2
`define BIBE_STATUS_PS_LO 5
`define BIBE_STATUS_PS_HI 6
`define BIBE_STATUS_RESET 8'h18
`define BIBE_STATUS_WMASK 8'he7
`define BIBE_PC_RESET 11'h000
`define BIBE_NOP_WORD 12'h000
`define BIBE_OP_BITSET 4'h5
`define BIBE_OP_BTC 4'h6
`define BIBE_OP_BTS 4'h7
`define BIBE_OP_JMP 3'h5
`define BIBE_OP_INC 6'h0a
`define BIBE_OP_ISZ 6'h0f
`define BIBE_WB_ERR_DATA 32'h0000_0000
`endif

// ==== bibe_pkg.sv ====
// Types shared by the execute block.
package bibe_pkg;
  typedef enum logic [2:0]
  {
    BIBE_OP_NONE = 3'b000,
    BIBE_OP_SETB = 3'b001,
    BIBE_OP_TSTC = 3'b010,
    BIBE_OP_TSTS = 3'b011,
    BIBE_OP_JUMP = 3'b100,
    BIBE_OP_INCR = 3'b101,
    BIBE_OP_INSZ = 3'b110
  } bibe_op_t;
  typedef enum logic [1:0]
  {
    BIBE_ST_HALT = 2'b00,
    BIBE_ST_FETCH = 2'b01,
    BIBE_ST_EXEC = 2'b10
  } bibe_state_t;
endpackage

// ==== bibe_decode.sv ====
// Instruction word decoder.
`timescale 1ns/1ps
`include "bibe_cfg.svh"
module bibe_decode
  import bibe_pkg::*;
(
  input wire logic [11:0] word,
  output bibe_op_t op,
  output logic [2:0] bit_idx,
  output logic [4:0] faddr,
  output logic dest,
  output logic [8:0] target
);
  always_comb
  begin
    bit_idx = word[7:5];
    faddr = word[4:0];
    dest = word[5];
    target = word[8:0];
    if (word[11:8] == `BIBE_OP_BITSET)
    begin
      op = BIBE_OP_SETB;
    end
    else if (word[11:8] == `BIBE_OP_BTC)
    begin
      op = BIBE_OP_TSTC;
    end
    else if (word[11:8] == `BIBE_OP_BTS)
    begin
      op = BIBE_OP_TSTS;
    end
    else if (word[11:9] == `BIBE_OP_JMP)
    begin
      op = BIBE_OP_JUMP;
    end
    else if (word[11:6] == `BIBE_OP_INC)
    begin
      op = BIBE_OP_INCR;
    end
    else if (word[11:6] == `BIBE_OP_ISZ)
    begin
      op = BIBE_OP_INSZ;
    end
    else
    begin
      op = BIBE_OP_NONE;
    end
  end
endmodule

// ==== bibe_core.sv ====
// Execute core for bit set, bit test, increment and branch instructions.
//
// The Wishbone slave port was left to the implementer.
`timescale 1ns/1ps
`include "bibe_cfg.svh"
module bibe_core
  import bibe_pkg::*;
#(
  parameter int FILE_DEPTH = 32
)
(
  input wire logic SYS_CLK,
  input wire logic RESET_N,
  input wire logic [31:0] WB_ADR_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  input wire logic [3:0] WB_SEL_I,
  input wire logic WB_WE_I,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  output logic WB_ACK_O,
  output logic WB_ERR_O,
  output logic [10:0] PROG_ADDR,
  input wire logic [11:0] PROG_DATA,
  output logic RUNNING
);
  // ****************************************
  // Parameter check.
  // ****************************************
  if (FILE_DEPTH != 32)
  begin : g_bad_depth
    $error("FILE_DEPTH must be 32.");
  end

  // ****************************************
  // State.
  // ****************************************
  logic [7:0] file_mem [0:FILE_DEPTH-1];
  logic [7:0] acc;
  logic [7:0] status;
  logic [10:0] pc;
  logic [11:0] ir;
  logic run_en;
  bibe_state_t state;
  bibe_op_t op;
  logic [2:0] bit_idx;
  logic [4:0] faddr;
  logic dest;
  logic [8:0] target;
  logic [7:0] operand;
  logic [7:0] sum;
  logic flush;
  logic [7:0] next_file;
  logic file_we;
  logic [10:0] next_pc;

  function automatic logic [7:0] bibe_plus_one(input logic [7:0] v);
    bibe_plus_one = v + 8'h01;
  endfunction

  bibe_decode u_decode
  (
    .word(ir),
    .op(op),
    .bit_idx(bit_idx),
    .faddr(faddr),
    .dest(dest),
    .target(target)
  );

  // Status lives at its own address; other file reads come from the array.
  assign operand = (faddr == `BIBE_REG_STATUS) ? status : file_mem[faddr];
  assign sum = bibe_plus_one(operand);

  // ****************************************
  // Execute decision.
  // ****************************************
  always_comb
  begin
    flush = 1'b0;
    file_we = 1'b0;
    next_file = operand;
    next_pc = pc + 11'h001;
    if (state == BIBE_ST_EXEC)
    begin
      unique case (op)
        BIBE_OP_SETB:
        begin
          file_we = 1'b1;
          next_file = operand | (8'h01 << bit_idx);
        end
        BIBE_OP_TSTC:
        begin
          flush = ~operand[bit_idx];
        end
        BIBE_OP_TSTS:
        begin
          flush = operand[bit_idx];
        end
        BIBE_OP_JUMP:
        begin
          flush = 1'b1;
          next_pc = {status[`BIBE_STATUS_PS_HI:`BIBE_STATUS_PS_LO], target};
        end
        BIBE_OP_INCR:
        begin
          file_we = dest;
          next_file = sum;
        end
        BIBE_OP_INSZ:
        begin
          file_we = dest;
          next_file = sum;
          flush = (sum == 8'h00);
        end
        BIBE_OP_NONE:
        begin
          flush = 1'b0;
        end
      endcase
    end
  end

  // ****************************************
  // Sequencer and program counter.
  // ****************************************
  always_ff @(posedge SYS_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      state <= BIBE_ST_HALT;
      pc <= `BIBE_PC_RESET;
      ir <= `BIBE_NOP_WORD;
    end
    else if (!run_en)
    begin
      state <= BIBE_ST_HALT;
    end
    else
    begin
      unique case (state)
        BIBE_ST_HALT:
        begin
          state <= BIBE_ST_FETCH;
        end
        BIBE_ST_FETCH:
        begin
          ir <= PROG_DATA;
          pc <= pc + 11'h001;
          state <= BIBE_ST_EXEC;
        end
        BIBE_ST_EXEC:
        begin
          if (flush)
          begin
            ir <= `BIBE_NOP_WORD;
          end
          else
          begin
            ir <= PROG_DATA;
          end
          pc <= next_pc;
          if (op == BIBE_OP_JUMP)
          begin
            state <= BIBE_ST_FETCH;
          end
        end
        default:
        begin
          state <= BIBE_ST_HALT;
        end
      endcase
    end
  end

  assign PROG_ADDR = pc;
  assign RUNNING = (state != BIBE_ST_HALT);

  // ****************************************
  // Register bus.
  // ****************************************
  logic wb_req;
  logic [4:0] wb_idx;
  logic wb_file;
  logic wb_hit;
  logic wb_wr;
  assign wb_req = WB_CYC_I & WB_STB_I & ~WB_ACK_O & ~WB_ERR_O;
  assign wb_idx = WB_ADR_I[6:2];
  assign wb_file = (WB_ADR_I[31:7] == 25'h0000001);
  assign wb_hit = (WB_ADR_I[31:7] == 25'h0000000) && (WB_ADR_I[1:0] == 2'h0)
    && (wb_idx <= `BIBE_REG_ACC) || wb_file;
  assign wb_wr = wb_req & wb_hit & WB_WE_I & WB_SEL_I[0];

  always_ff @(posedge SYS_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      WB_ACK_O <= 1'b0;
      WB_ERR_O <= 1'b0;
      WB_DAT_O <= 32'h0000_0000;
    end
    else
    begin
      WB_ACK_O <= wb_req & wb_hit;
      WB_ERR_O <= wb_req & ~wb_hit;
      WB_DAT_O <= `BIBE_WB_ERR_DATA;
      if (wb_req & wb_hit & wb_file)
      begin
        WB_DAT_O <= {24'h000000, file_mem[wb_idx]};
      end
      else if (wb_req & wb_hit)
      begin
        unique case (wb_idx)
          `BIBE_REG_CONFIG: WB_DAT_O <= {31'h00000000, run_en};
          `BIBE_REG_PC_LO: WB_DAT_O <= {24'h000000, pc[7:0]};
          `BIBE_REG_PC_HI: WB_DAT_O <= {24'h000000, ir[11:8], 1'b0, pc[10:8]};
          `BIBE_REG_STATUS: WB_DAT_O <= {24'h000000, status};
          `BIBE_REG_ACC: WB_DAT_O <= {24'h000000, acc};
          default: WB_DAT_O <= `BIBE_WB_ERR_DATA;
        endcase
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      run_en <= 1'b0;
    end
    else if (wb_wr && !wb_file && wb_idx == `BIBE_REG_CONFIG)
    begin
      run_en <= WB_DAT_I[0];
    end
  end

  // ****************************************
  // Accumulator, status and file array.
  // ****************************************
  always_ff @(posedge SYS_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      acc <= 8'h00;
    end
    else if (state == BIBE_ST_EXEC && run_en && (op == BIBE_OP_INCR || op == BIBE_OP_INSZ)
      && !dest)
    begin
      acc <= sum;
    end
    else if (wb_wr && !wb_file && wb_idx == `BIBE_REG_ACC)
    begin
      acc <= WB_DAT_I[7:0];
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      status <= `BIBE_STATUS_RESET;
    end
    else if (state == BIBE_ST_EXEC && run_en && file_we && faddr == `BIBE_REG_STATUS)
    begin
      status <= next_file;
      if (op == BIBE_OP_INCR)
      begin
        status[`BIBE_STATUS_Z] <= (sum == 8'h00);
      end
    end
    else if (state == BIBE_ST_EXEC && run_en && op == BIBE_OP_INCR)
    begin
      status[`BIBE_STATUS_Z] <= (sum == 8'h00);
    end
    else if (wb_wr && !wb_file && wb_idx == `BIBE_REG_STATUS)
    begin
      status <= (status & ~`BIBE_STATUS_WMASK) | (WB_DAT_I[7:0] & `BIBE_STATUS_WMASK);
    end
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (state == BIBE_ST_EXEC && run_en && file_we)
    begin
      file_mem[faddr] <= next_file;
    end
    else if (wb_wr && wb_file)
    begin
      file_mem[wb_idx] <= WB_DAT_I[7:0];
    end
  end
endmodule

// ==== bibe_core_sva.sv ====
// Checker for the bus and sequencer ports of the execute core.
`timescale 1ns/1ps
module bibe_core_chk
(
  input wire logic SYS_CLK,
  input wire logic RESET_N,
  input wire logic [31:0] WB_ADR_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_ACK_O,
  input wire logic WB_ERR_O,
  input wire logic [10:0] PROG_ADDR,
  input wire logic RUNNING
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESET_N);
  property p_ans;
    WB_CYC_I && WB_STB_I && !WB_ACK_O && !WB_ERR_O |=> WB_ACK_O || WB_ERR_O;
  endproperty
  a_ans: assert property (p_ans) else $error("bus answer late");
  property p_pulse;
    WB_ACK_O |=> !WB_ACK_O;
  endproperty
  a_pulse: assert property (p_pulse) else $error("ack longer than one cycle");
  property p_excl;
    !(WB_ACK_O && WB_ERR_O);
  endproperty
  a_excl: assert property (p_excl) else $error("ack and err together");
  property p_err_data;
    WB_ERR_O |-> WB_DAT_O == 32'h0;
  endproperty
  a_err_data: assert property (p_err_data) else $error("err with data");
  property p_unmapped;
    WB_CYC_I && WB_STB_I && !WB_ACK_O && !WB_ERR_O && WB_ADR_I == 32'h40 |=> WB_ERR_O;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access acked");
  property p_upper;
    WB_ACK_O |-> WB_DAT_O[31:8] == 24'h0;
  endproperty
  a_upper: assert property (p_upper) else $error("upper read bits set");
  property p_halt;
    !RUNNING |=> $stable(PROG_ADDR);
  endproperty
  a_halt: assert property (p_halt) else $error("counter moved while halted");
  property p_step;
    $rose(RUNNING) |=> PROG_ADDR == $past(PROG_ADDR) + 11'h1;
  endproperty
  a_step: assert property (p_step) else $error("fetch did not advance");
endmodule
bind bibe_core bibe_core_chk chk
(
  .SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .WB_ADR_I(WB_ADR_I), .WB_DAT_O(WB_DAT_O),
  .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O), .WB_ERR_O(WB_ERR_O),
  .PROG_ADDR(PROG_ADDR), .RUNNING(RUNNING)
);

// ==== bibe_prog_mem.sv ====
// Program memory model answering in the same cycle.
`timescale 1ns/1ps
module bibe_prog_mem
(
  input wire logic [10:0] addr,
  output logic [11:0] data
);
  logic [11:0] mem [0:2047];
  assign data = mem[addr];
endmodule

// ==== bibe_core_tb_top.sv ====
// Self-checking bench for the execute core.
`timescale 1ns/1ps
module bibe_core_tb_top;
  typedef struct {logic [7:0] init; logic [11:0] word; logic [7:0] f8, mark, acc, st;} bibe_row_t;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [31:0] adr = 32'h0;
  logic [31:0] dat = 32'h0;
  logic we = 1'b0;
  logic [3:0] sel = 4'hf;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic [31:0] dat_o;
  logic ack;
  logic err;
  logic e;
  logic [10:0] pa;
  logic [11:0] pd;
  logic running;
  logic [31:0] q;
  int n_errors = 0;
  int tests_run = 0;
  int cycles = 0;
  bibe_row_t rows [9] = '{
    '{8'h0a, 12'h5e8, 8'h8a, 8'h01, 8'h00, 8'h18},
    '{8'h0a, 12'h628, 8'h0a, 8'h01, 8'h00, 8'h18},
    '{8'h0a, 12'h608, 8'h0a, 8'h00, 8'h00, 8'h18},
    '{8'h0a, 12'h728, 8'h0a, 8'h00, 8'h00, 8'h18},
    '{8'h0a, 12'h748, 8'h0a, 8'h01, 8'h00, 8'h18},
    '{8'hff, 12'h2a8, 8'h00, 8'h01, 8'h00, 8'h1c},
    '{8'h41, 12'h288, 8'h41, 8'h01, 8'h42, 8'h18},
    '{8'hff, 12'h3e8, 8'h00, 8'h00, 8'h00, 8'h18},
    '{8'h05, 12'h3c8, 8'h05, 8'h01, 8'h06, 8'h18}};
  always #2 clk = ~clk;
  bibe_prog_mem pm (.addr(pa), .data(pd));
  bibe_core dut
  (
    .SYS_CLK(clk), .RESET_N(rst_n), .WB_ADR_I(adr), .WB_DAT_I(dat), .WB_DAT_O(dat_o),
    .WB_SEL_I(sel), .WB_WE_I(we), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_ACK_O(ack),
    .WB_ERR_O(err), .PROG_ADDR(pa), .PROG_DATA(pd), .RUNNING(running)
  );
  task close_out;
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wb(input logic [31:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    adr <= a;
    we <= w;
    dat <= d;
    @(posedge clk);
    while (ack !== 1'b1 && err !== 1'b1) @(posedge clk);
    q = dat_o;
    e = err;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task rst(input int n);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (n) @(posedge clk);
    rst_n <= 1'b1;
  endtask
  task run;
    wb(32'h0, 1'b1, 32'h1);
    repeat (12) @(posedge clk);
    wb(32'h0, 1'b1, 32'h0);
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_errors++;
      close_out();
    end
  end
  // ****************
  // Test sequence.
  // ****************
  initial
  begin
    for (int i = 0; i < 2048; i++) pm.mem[i] = 12'ha02;
    pm.mem[1] = 12'h50a;
    rst(8);
    wb(32'h0c, 1'b0, 32'h0);
    chk(q[7:0], 8'h18);
    wb(32'h40, 1'b0, 32'h0);
    chk({7'h0, e}, 8'h01);
    foreach (rows[i])
    begin
      rst(2);
      wb(32'ha0, 1'b1, {24'h0, rows[i].init});
      wb(32'ha8, 1'b1, 32'h0);
      pm.mem[0] = rows[i].word;
      run();
      wb(32'ha0, 1'b0, 32'h0);
      chk(q[7:0], rows[i].f8);
      wb(32'ha8, 1'b0, 32'h0);
      chk(q[7:0], rows[i].mark);
      wb(32'h10, 1'b0, 32'h0);
      chk(q[7:0], rows[i].acc);
      wb(32'h0c, 1'b0, 32'h0);
      chk(q[7:0], rows[i].st);
    end
    rst(2);
    wb(32'ha8, 1'b1, 32'h0);
    wb(32'h0c, 1'b1, 32'h60);
    wb(32'h0c, 1'b0, 32'h0);
    chk(q[7:0], 8'h78);
    pm.mem[0] = 12'ha55;
    pm.mem[1] = 12'h52a;
    pm.mem[12'h655] = 12'h50a;
    pm.mem[12'h656] = 12'ha56;
    run();
    wb(32'ha8, 1'b0, 32'h0);
    chk(q[7:0], 8'h01);
    wb(32'h0, 1'b1, 32'h1);
    repeat (6) @(posedge clk);
    rst(2);
    @(posedge clk);
    chk({7'h0, running}, 8'h00);
    wb(32'h04, 1'b0, 32'h0);
    chk(q[7:0], 8'h00);
    sel <= 4'he;
    wb(32'h10, 1'b1, 32'h55);
    chk({7'h0, e}, 8'h00);
    sel <= 4'hf;
    wb(32'h10, 1'b0, 32'h0);
    chk(q[7:0], 8'h00);
    close_out();
  end
endmodule
